// ==== logic/lfs_defines.svh ====
// offsets, bit positions, reset values and timing counts of the fault status block
`ifndef LFS_DEFINES_SVH
`define LFS_DEFINES_SVH

`define LFS_CMD_BIAS_LIMIT     8'h11
`define LFS_CMD_FAULT_FLAGS    8'h12
`define LFS_DEV_ADDR           7'h2a

`define LFS_BIT_READY          10
`define LFS_BIT_TX_ON          9
`define LFS_BIT_EN_PIN         8
`define LFS_BIT_TWICE          7
`define LFS_BIT_ONCE           6
`define LFS_BIT_FAULTED        5
`define LFS_COR_MSB            4
`define LFS_COR_W              5
`define LFS_COR_RESET          5'h10

`define LFS_CFG_AUTO_SHUTDN    6
`define LFS_CFG_OVER_PWR_EN    2
`define LFS_CFG_UNDER_PWR_EN   1
`define LFS_CFG_OVER_CUR_EN    0

`define LFS_BIAS_LIMIT_W       7
`define LFS_BIAS_LIMIT_RESET   7'h00

`define LFS_SYNC_W             3
`define LFS_SYNC_EN_PIN        0
`define LFS_SYNC_RD            1
`define LFS_SYNC_WR            2

`define LFS_SYS_CLK_MHZ        125
`define LFS_REPEAT_WINDOW_US   25000
`define LFS_REPEAT_WINDOW_CYCLES (`LFS_REPEAT_WINDOW_US * `LFS_SYS_CLK_MHZ)
`define LFS_WINDOW_CNT_W       22

`endif

// ==== logic/lfs_pkg.sv ====
// state types of the fault status block
package lfs_pkg;
	typedef enum logic [2:0] {
		LK_CLEAR,
		LK_FAULT,
		LK_ONCE,
		LK_WATCH,
		LK_TWICE
	} lfs_lock_type;

	typedef enum logic [3:0] {
		LN_IDLE,
		LN_ADDR,
		LN_ADDR_ACK,
		LN_CMD,
		LN_CMD_ACK,
		LN_WDATA,
		LN_WDATA_ACK,
		LN_RDATA,
		LN_RDATA_ACK
	} lfs_link_type;
endpackage

// ==== logic/lfs_fault_status.sv ====
// fault flags, repeat-fault lockout and two-wire register access of the laser driver
// Notes on behaviour
// [R1] ready bit 10 when settled, fault clears it
// [R2] bit 9: pin and soft enable, no fault
// [R3] bit 8 mirrors raw enable pin level
// [R4] lockout: bit 6 set on disable after fault
// [R5] refault within 25ms sets bit 7, else clear
// [R6] bit 7 locks transmitter off until power cycle
// [R7] bit 5 faulted; shutdown only with auto shutdown
// [R8] undervoltage bit 4 set at power-up, cleared on read
// [R9] host reads status right after power-up
// [R10] bit 3 set on failed memory load
// [R11] bit 2 overpower, closed-loop mode and enabled
// [R12] bit 1 underpower, closed-loop mode and enabled
// [R13] bit 0 bias current above limit register
// [R14] auto shutdown disables transmitter on fault
// [R15] detector enables are config bits 2,1,0
// [R16] clear after capture; events during read kept
`include "lfs_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module lfs_fault_status
	import lfs_pkg::*;
#(
	parameter int unsigned REPEAT_WINDOW_CYCLES = `LFS_REPEAT_WINDOW_CYCLES,
	parameter logic [6:0]  DEV_ADDR             = `LFS_DEV_ADDR
) (
	input  wire logic                          sys_clk,
	input  wire logic                          arst_n,
	input  wire logic                          sclClk,
	input  wire logic                          sdaIn,
	output var  logic                          sdaOut,
	output var  logic                          sdaOe,
	input  wire logic                          enPin,
	input  wire logic                          softEn,
	input  wire logic                          enInvert,
	input  wire logic                          repeatLockoutEn,
	input  wire logic [15:0]                   cfgWord,
	input  wire logic                          closedLoopPowerMode,
	input  wire logic [`LFS_BIAS_LIMIT_W-1:0]  biasCurrentCode,
	input  wire logic                          monitorAboveSetpoint,
	input  wire logic                          monitorBelowSetpoint,
	input  wire logic                          supplyUndervoltage,
	input  wire logic                          currentsSettled,
	input  wire logic                          nvLoadStart,
	input  wire logic                          nvLoadDone,
	input  wire logic                          nvLoadOk,
	output var  logic                          laserDriveEn
);
	localparam int CNT_W = `LFS_WINDOW_CNT_W;

	if (REPEAT_WINDOW_CYCLES < 1 || REPEAT_WINDOW_CYCLES >= (1 << CNT_W)) begin : gBadWindow
		$error("repeat window count does not fit the counter");
	end

	// reset release through two flops; both domains use this copy
	logic [1:0] rstPipe_q;
	logic       rstN;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rstPipe_q <= 2'b00;
		end else begin
			rstPipe_q <= {rstPipe_q[0], 1'b1};
		end
	end
	assign rstN = rstPipe_q[1];

	// link side state
	lfs_link_type               linkState_q, linkState_d;
	logic [2:0]                 bitCnt_q, bitCnt_d;
	logic [7:0]                 shift_q, shift_d;
	logic [7:0]                 cmd_q, cmd_d;
	logic                       byteIdx_q, byteIdx_d;
	logic [7:0]                 wrLow_q, wrLow_d;
	logic [`LFS_BIAS_LIMIT_W-1:0] wrData_q, wrData_d;
	logic                       wrTog_q, wrTog_d;
	logic                       rdTog_q, rdTog_d;
	logic                       startSeen_q;
	logic                       startTog_q;
	logic                       sdaOe_d;

	// system side state
	logic [`LFS_SYNC_W-1:0]     sync1_q, sync2_q, sync3_q, filt_q, filt_d;
	logic [`LFS_COR_W-1:0]      cor_q, cor_d;
	logic                       faulted_q, faulted_d;
	logic                       txBit_q, txBit_d;
	logic                       ready_q, ready_d;
	logic                       drive_q, drive_d;
	logic                       nvBusy_q, nvBusy_d;
	lfs_lock_type               lock_q, lock_d;
	logic [CNT_W-1:0]           winCnt_q, winCnt_d;
	logic [`LFS_BIAS_LIMIT_W-1:0] limit_q, limit_d;
	logic [15:0]                statusSnap_q, statusSnap_d;
	logic [15:0]                limitSnap_q, limitSnap_d;

	function automatic logic [15:0] readWord(input logic [7:0] cmd,
		input logic [15:0] status, input logic [15:0] limit);
		case (cmd)
			`LFS_CMD_FAULT_FLAGS: readWord = status;
			`LFS_CMD_BIAS_LIMIT:  readWord = limit;
			default:              readWord = 16'h0000;
		endcase
	endfunction

	// start condition: sda falls while scl is high; the toggle settles well before the next
	// rising scl edge, so it is read there without a synchroniser
	always_ff @(negedge sdaIn or negedge rstN) begin
		if (!rstN) begin
			startTog_q <= 1'b0;
		end else if (sclClk) begin
			startTog_q <= ~startTog_q;
		end
	end

	logic       newFrame;
	logic [7:0] shiftIn;
	logic [15:0] curWord;
	assign newFrame = startTog_q != startSeen_q;
	assign shiftIn  = {shift_q[6:0], sdaIn};
	assign curWord  = readWord(cmd_q, statusSnap_q, limitSnap_q);

	always_comb begin
		linkState_d = linkState_q;
		bitCnt_d    = bitCnt_q + 3'h1;
		shift_d     = shiftIn;
		cmd_d       = cmd_q;
		byteIdx_d   = byteIdx_q;
		wrLow_d     = wrLow_q;
		wrData_d    = wrData_q;
		wrTog_d     = wrTog_q;
		rdTog_d     = rdTog_q;
		if (newFrame) begin
			linkState_d = LN_ADDR;
			bitCnt_d    = 3'h1;
		end else begin
			case (linkState_q)
				LN_ADDR: begin
					if (bitCnt_q == 3'h7) begin
						if (shiftIn[7:1] == DEV_ADDR) begin
							linkState_d = LN_ADDR_ACK;
							byteIdx_d   = 1'b0;
							// snapshot asked early, clear happens in the system domain [R16]
							if (sdaIn) begin
								rdTog_d = ~rdTog_q;
							end
						end else begin
							linkState_d = LN_IDLE;
						end
					end
				end
				LN_ADDR_ACK: begin
					bitCnt_d    = 3'h0;
					linkState_d = shift_q[0] ? LN_RDATA : LN_CMD;
				end
				LN_CMD: begin
					if (bitCnt_q == 3'h7) begin
						cmd_d       = shiftIn;
						linkState_d = LN_CMD_ACK;
					end
				end
				LN_CMD_ACK: begin
					bitCnt_d    = 3'h0;
					byteIdx_d   = 1'b0;
					linkState_d = LN_WDATA;
				end
				LN_WDATA: begin
					if (bitCnt_q == 3'h7) begin
						linkState_d = LN_WDATA_ACK;
						if (!byteIdx_q) begin
							wrLow_d = shiftIn;
						end else if (cmd_q == `LFS_CMD_BIAS_LIMIT) begin
							wrData_d = wrLow_q[`LFS_BIAS_LIMIT_W-1:0];
							wrTog_d  = ~wrTog_q;
						end
					end
				end
				LN_WDATA_ACK: begin
					bitCnt_d    = 3'h0;
					byteIdx_d   = 1'b1;
					linkState_d = LN_WDATA;
				end
				LN_RDATA: begin
					if (bitCnt_q == 3'h7) begin
						linkState_d = LN_RDATA_ACK;
					end
				end
				LN_RDATA_ACK: begin
					bitCnt_d    = 3'h0;
					byteIdx_d   = ~byteIdx_q;
					linkState_d = sdaIn ? LN_IDLE : LN_RDATA;
				end
				default: begin
					linkState_d = LN_IDLE;
				end
			endcase
		end
	end

	// drive low for acks and zero data bits; low byte first
	always_comb begin
		case (linkState_q)
			LN_ADDR_ACK, LN_CMD_ACK, LN_WDATA_ACK: sdaOe_d = 1'b1;
			LN_RDATA: sdaOe_d = ~curWord[{byteIdx_q, ~bitCnt_q}];
			default: sdaOe_d = 1'b0;
		endcase
	end

	always_ff @(posedge sclClk or negedge rstN) begin
		if (!rstN) begin
			linkState_q <= LN_IDLE;
			bitCnt_q    <= 3'h0;
			shift_q     <= 8'h00;
			cmd_q       <= 8'h00;
			byteIdx_q   <= 1'b0;
			wrLow_q     <= 8'h00;
			wrData_q    <= `LFS_BIAS_LIMIT_RESET;
			wrTog_q     <= 1'b0;
			rdTog_q     <= 1'b0;
			startSeen_q <= 1'b0;
		end else begin
			linkState_q <= linkState_d;
			bitCnt_q    <= bitCnt_d;
			shift_q     <= shift_d;
			cmd_q       <= cmd_d;
			byteIdx_q   <= byteIdx_d;
			wrLow_q     <= wrLow_d;
			wrData_q    <= wrData_d;
			wrTog_q     <= wrTog_d;
			rdTog_q     <= rdTog_d;
			startSeen_q <= startTog_q;
		end
	end

	// sda changes only while scl is low
	always_ff @(negedge sclClk or negedge rstN) begin
		if (!rstN) begin
			sdaOe  <= 1'b0;
			sdaOut <= 1'b0;
		end else begin
			sdaOe  <= sdaOe_d;
			sdaOut <= 1'b0;
		end
	end

	// system side: three-flop input filter, a change counts once stages two and three agree
	logic [`LFS_SYNC_W-1:0] steady;
	logic                   rdEvt, wrEvt, enActive, requestOn, faultNow, nvFail, corClr;
	logic [`LFS_COR_W-1:0]  events;
	logic [15:0]            statusWord;
	assign steady = ~(sync2_q ^ sync3_q);
	assign rdEvt  = steady[`LFS_SYNC_RD] && (sync3_q[`LFS_SYNC_RD] != filt_q[`LFS_SYNC_RD]);
	assign wrEvt  = steady[`LFS_SYNC_WR] && (sync3_q[`LFS_SYNC_WR] != filt_q[`LFS_SYNC_WR]);

	always_comb begin
		filt_d = (steady & sync3_q) | (~steady & filt_q);
		nvFail = nvBusy_q && nvLoadDone && !nvLoadOk;
		events = {supplyUndervoltage,                                            // [R8]
			nvFail,                                                                  // [R10]
			closedLoopPowerMode && cfgWord[`LFS_CFG_OVER_PWR_EN] && monitorAboveSetpoint,  // [R11] [R15]
			closedLoopPowerMode && cfgWord[`LFS_CFG_UNDER_PWR_EN] && monitorBelowSetpoint, // [R12] [R15]
			cfgWord[`LFS_CFG_OVER_CUR_EN] && (biasCurrentCode > limit_q)};          // [R13] [R15]
		faultNow  = |events;
		enActive  = filt_q[`LFS_SYNC_EN_PIN] ^ enInvert;
		requestOn = enActive && softEn && (lock_q != LK_TWICE);                   // [R6]

		statusWord = 16'h0000;
		statusWord[`LFS_BIT_READY]   = ready_q;
		statusWord[`LFS_BIT_TX_ON]   = txBit_q;
		statusWord[`LFS_BIT_EN_PIN]  = filt_q[`LFS_SYNC_EN_PIN];                 // [R3]
		statusWord[`LFS_BIT_TWICE]   = lock_q == LK_TWICE;
		statusWord[`LFS_BIT_ONCE]    = (lock_q == LK_ONCE) || (lock_q == LK_WATCH);
		statusWord[`LFS_BIT_FAULTED] = faulted_q;
		statusWord[`LFS_COR_MSB:0]   = cor_q;

		// capture first, then clear; a new event wins over the clear [R16]
		statusSnap_d = rdEvt ? statusWord : statusSnap_q;
		limitSnap_d  = rdEvt ? {{(16-`LFS_BIAS_LIMIT_W){1'b0}}, limit_q} : limitSnap_q;
		// only a status read clears; cmd_q has stood since the command byte, long settled
		corClr       = rdEvt && (cmd_q == `LFS_CMD_FAULT_FLAGS);
		cor_d        = (corClr ? {`LFS_COR_W{1'b0}} : cor_q) | events;           // [R8] [R16]
		limit_d      = wrEvt ? wrData_q : limit_q;
		nvBusy_d     = nvLoadStart ? 1'b1 : (nvLoadDone ? 1'b0 : nvBusy_q);

		// faulted state leaves only once requestOn drops (enables off or second-fault lockout) with no fault present
		faulted_d = faultNow ? 1'b1 : (requestOn ? faulted_q : 1'b0);           // [R7]
		txBit_d   = requestOn && !faulted_d;                                      // [R2]
		ready_d   = txBit_d && currentsSettled;                                   // [R1]
		drive_d   = requestOn && !(faulted_d && cfgWord[`LFS_CFG_AUTO_SHUTDN]);  // [R7] [R14]

		lock_d   = lock_q;
		winCnt_d = winCnt_q;
		case (lock_q)
			LK_CLEAR: begin
				if (faultNow) begin
					lock_d = LK_FAULT;
				end
			end
			LK_FAULT: begin
				if (!requestOn) begin
					lock_d = LK_ONCE;                                             // [R4]
				end
			end
			LK_ONCE: begin
				winCnt_d = {CNT_W{1'b0}};
				if (requestOn) begin
					lock_d = LK_WATCH;
				end
			end
			LK_WATCH: begin
				winCnt_d = winCnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
				if (faultNow) begin
					lock_d = LK_TWICE;                                            // [R5]
				end else if (!requestOn) begin
					lock_d = LK_ONCE;
				end else if (winCnt_q == CNT_W'(REPEAT_WINDOW_CYCLES - 1)) begin
					lock_d = LK_CLEAR;                                            // [R5]
				end
			end
			LK_TWICE: begin
				lock_d = LK_TWICE;                                                // [R6]
			end
			default: begin
				lock_d = LK_CLEAR;
			end
		endcase
		// lockout off: no tracking, but a latched second fault still holds
		if (!repeatLockoutEn && lock_q != LK_TWICE) begin
			lock_d = LK_CLEAR;
		end
	end

	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			sync1_q      <= {`LFS_SYNC_W{1'b0}};
			sync2_q      <= {`LFS_SYNC_W{1'b0}};
			sync3_q      <= {`LFS_SYNC_W{1'b0}};
			filt_q       <= {`LFS_SYNC_W{1'b0}};
			cor_q        <= `LFS_COR_RESET;
			faulted_q    <= 1'b1;
			txBit_q      <= 1'b0;
			ready_q      <= 1'b0;
			drive_q      <= 1'b0;
			nvBusy_q     <= 1'b0;
			lock_q       <= LK_ONCE;
			winCnt_q     <= {CNT_W{1'b0}};
			limit_q      <= `LFS_BIAS_LIMIT_RESET;
			statusSnap_q <= 16'h0000;
			limitSnap_q  <= 16'h0000;
		end else begin
			sync1_q      <= {wrTog_q, rdTog_q, enPin};
			sync2_q      <= sync1_q;
			sync3_q      <= sync2_q;
			filt_q       <= filt_d;
			cor_q        <= cor_d;
			faulted_q    <= faulted_d;
			txBit_q      <= txBit_d;
			ready_q      <= ready_d;
			drive_q      <= drive_d;
			nvBusy_q     <= nvBusy_d;
			lock_q       <= lock_d;
			winCnt_q     <= winCnt_d;
			limit_q      <= limit_d;
			statusSnap_q <= statusSnap_d;
			limitSnap_q  <= limitSnap_d;
		end
	end

	assign laserDriveEn = drive_q;
endmodule

`default_nettype wire

// ==== testbench/lfs_fault_status_props.sv ====
// assertion checker on the fault status block ports
`timescale 1ns/10ps
`default_nettype none
module lfs_fault_status_props (
	input wire logic        sys_clk,
	input wire logic        arst_n,
	input wire logic        sclClk,
	input wire logic        sdaOut,
	input wire logic        sdaOe,
	input wire logic        softEn,
	input wire logic        repeatLockoutEn,
	input wire logic [15:0] cfgWord,
	input wire logic        closedLoopPowerMode,
	input wire logic        monitorAboveSetpoint,
	input wire logic        monitorBelowSetpoint,
	input wire logic        supplyUndervoltage,
	input wire logic        nvLoadStart,
	input wire logic        nvLoadDone,
	input wire logic        nvLoadOk,
	input wire logic        laserDriveEn
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	property p_sdaLow;
		sdaOut == 1'b0;
	endproperty
	a_sdaLow: assert property (p_sdaLow) else $error("sda data level not low");
	// sda may only move while scl is low, else it reads as start or stop
	property p_oeEdge;
		$changed(sdaOe) |-> !sclClk;
	endproperty
	a_oeEdge: assert property (p_oeEdge) else $error("sda moved with scl high");
	property p_driveSoft;
		laserDriveEn |-> $past(softEn);
	endproperty
	a_driveSoft: assert property (p_driveSoft) else $error("drive without soft enable");
	property p_keep;
		laserDriveEn && softEn && !cfgWord[6] && !repeatLockoutEn |=> laserDriveEn;
	endproperty
	a_keep: assert property (p_keep) else $error("drive dropped without auto shutdown");
	property p_uvShut;
		supplyUndervoltage && cfgWord[6] |-> ##[1:4] !laserDriveEn;
	endproperty
	a_uvShut: assert property (p_uvShut) else $error("no shutdown on undervoltage");
	property p_overShut;
		monitorAboveSetpoint && closedLoopPowerMode && cfgWord[2] && cfgWord[6]
			|-> ##[1:4] !laserDriveEn;
	endproperty
	a_overShut: assert property (p_overShut) else $error("no shutdown on overpower");
	property p_underShut;
		monitorBelowSetpoint && closedLoopPowerMode && cfgWord[1] && cfgWord[6]
			|-> ##[1:4] !laserDriveEn;
	endproperty
	a_underShut: assert property (p_underShut) else $error("no shutdown on underpower");
	property p_nvShut;
		nvLoadStart ##1 (nvLoadDone && !nvLoadOk && cfgWord[6]) |-> ##[1:4] !laserDriveEn;
	endproperty
	a_nvShut: assert property (p_nvShut) else $error("no shutdown on load failure");
endmodule
bind lfs_fault_status lfs_fault_status_props i_props (
	.sys_clk(sys_clk), .arst_n(arst_n), .sclClk(sclClk), .sdaOut(sdaOut), .sdaOe(sdaOe),
	.softEn(softEn), .repeatLockoutEn(repeatLockoutEn), .cfgWord(cfgWord),
	.closedLoopPowerMode(closedLoopPowerMode), .monitorAboveSetpoint(monitorAboveSetpoint),
	.monitorBelowSetpoint(monitorBelowSetpoint), .supplyUndervoltage(supplyUndervoltage),
	.nvLoadStart(nvLoadStart), .nvLoadDone(nvLoadDone), .nvLoadOk(nvLoadOk),
	.laserDriveEn(laserDriveEn)
);
`default_nettype wire

// ==== testbench/lfs_host_model.sv ====
// two-wire host model: frames clocked at 64 ns, sda on a pulled-up wire
`timescale 1ns/10ps
`default_nettype none
module lfs_host_model (
	output var  logic sclClk,
	output wire logic sdaIn,
	input  wire logic sdaOe
);
	logic hostSda = 1'b1;
	initial sclClk = 1'b1;
	// pull-up: a released wire reads high, never the last value
	assign sdaIn = hostSda && !sdaOe;
	task automatic bitx(input logic b, output logic r);
		hostSda = b;
		#32 sclClk = 1'b1;
		r = sdaIn;
		#32 sclClk = 1'b0;
	endtask
	// also the repeated start; scl stands high between frames
	task automatic start;
		hostSda = 1'b1;
		#32 sclClk = 1'b1;
		#32 hostSda = 1'b0;
		#32 sclClk = 1'b0;
	endtask
	task automatic stop;
		hostSda = 1'b0;
		#32 sclClk = 1'b1;
		#32 hostSda = 1'b1;
	endtask
	task automatic tx(input logic [7:0] b, inout logic ok);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(b[i], r);
		bitx(1'b1, r);
		ok = ok && !r;
	endtask
	task automatic rx(input logic nack, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, r);
			b[i] = r;
		end
		bitx(nack, r);
	endtask
	task automatic wrWord(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d,
		output logic ok);
		ok = 1'b1;
		start;
		tx({a, 1'b0}, ok);
		tx(c, ok);
		tx(d[7:0], ok);
		tx(d[15:8], ok);
		stop;
	endtask
	task automatic rdWord(input logic [6:0] a, input logic [7:0] c, output logic [15:0] d,
		output logic ok);
		logic [7:0] lo;
		logic [7:0] hi;
		ok = 1'b1;
		start;
		tx({a, 1'b0}, ok);
		tx(c, ok);
		start;
		tx({a, 1'b1}, ok);
		rx(1'b0, lo);
		rx(1'b1, hi);
		stop;
		d = {hi, lo};
	endtask
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// self-checking bench for the fault status block
`include "lfs_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module testbench;
	localparam logic [7:0] FLT = `LFS_CMD_FAULT_FLAGS;
	localparam logic [7:0] LIM = `LFS_CMD_BIAS_LIMIT;
	logic        sys_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        sclClk;
	logic        sdaIn;
	logic        sdaOe;
	logic        laserDriveEn;
	logic        softEn = 1'b0;
	logic        enPin = 1'b1;
	logic        enInvert = 1'b0;
	logic        lockEn = 1'b1;
	logic [15:0] cfgWord = 16'h0007;
	logic        loopMode = 1'b0;
	logic [6:0]  biasCode = 7'h00;
	logic        overPwr = 1'b0;
	logic        underPwr = 1'b0;
	logic        underVolt = 1'b0;
	logic        settled = 1'b0;
	logic        nvStart = 1'b0;
	logic        nvDone = 1'b0;
	int          num_errors = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	always #4 sys_clk = ~sys_clk;
	lfs_host_model i_host (.sclClk(sclClk), .sdaIn(sdaIn), .sdaOe(sdaOe));
	// window shortened so the lockout timing fits the run
	lfs_fault_status #(.REPEAT_WINDOW_CYCLES(50)) i_dut (
		.sys_clk(sys_clk), .arst_n(arst_n), .sclClk(sclClk), .sdaIn(sdaIn), .sdaOut(),
		.sdaOe(sdaOe), .enPin(enPin), .softEn(softEn), .enInvert(enInvert),
		.repeatLockoutEn(lockEn),
		.cfgWord(cfgWord), .closedLoopPowerMode(loopMode), .biasCurrentCode(biasCode),
		.monitorAboveSetpoint(overPwr), .monitorBelowSetpoint(underPwr),
		.supplyUndervoltage(underVolt), .currentsSettled(settled), .nvLoadStart(nvStart),
		.nvLoadDone(nvDone), .nvLoadOk(1'b0), .laserDriveEn(laserDriveEn)
	);
	task automatic test_done;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] mask);
		samples_checked++;
		if ((got & mask) !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h want %h", $time, got & mask, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic rdc(input logic [7:0] c, input logic [15:0] exp, input logic [15:0] mask);
		logic [15:0] v;
		logic        ok;
		i_host.rdWord(`LFS_DEV_ADDR, c, v, ok);
		chk({15'h0, ok}, 16'h1, 16'h1);
		chk(v, exp, mask);
		cyc(1);
	endtask
	task automatic drv(input logic e);
		chk({15'h0, laserDriveEn}, {15'h0, e}, 16'h1);
	endtask
	task automatic evt(input int k);
		@(negedge sys_clk);
		underPwr = (k == 1);
		overPwr = (k == 2);
		nvStart = (k == 3);
		underVolt = (k == 4);
		@(negedge sys_clk);
		{underPwr, overPwr, nvStart, underVolt} = 4'h0;
		nvDone = (k == 3);
		@(negedge sys_clk);
		nvDone = 1'b0;
	endtask
	task automatic reen;
		softEn = 1'b0;
		cyc(8);
		softEn = 1'b1;
		cyc(8);
	endtask
	task automatic t_powerUp;
		logic [15:0] v;
		logic        ok;
		rdc(FLT, 16'h0150, 16'hffdf);
		i_host.rdWord(7'h2b, FLT, v, ok);
		chk({15'h0, ok}, 16'h0, 16'h1);
		cyc(1);
		rdc(FLT, 16'h0140, 16'hffdf);
	endtask
	task automatic t_enable;
		settled = 1'b1;
		softEn = 1'b1;
		cyc(100);
		rdc(FLT, 16'h0700, 16'hffff);
		drv(1'b1);
		lockEn = 1'b0;
		cyc(20);
		lockEn = 1'b1;
		// pin low but inverted: still enabled, bit 8 shows the raw low level
		enPin = 1'b0;
		enInvert = 1'b1;
		cyc(8);
		rdc(FLT, 16'h0600, 16'hffff);
		drv(1'b1);
		enPin = 1'b1;
		enInvert = 1'b0;
		cyc(8);
		rdc(FLT, 16'h0700, 16'hffff);
	endtask
	task automatic t_overCurrent;
		logic ok;
		i_host.wrWord(`LFS_DEV_ADDR, LIM, 16'hff85, ok);
		chk({15'h0, ok}, 16'h1, 16'h1);
		cyc(1);
		rdc(LIM, 16'h0005, 16'hffff);
		cfgWord = 16'h0006;
		biasCode = 7'h06;
		cyc(4);
		cfgWord = 16'h0007;
		biasCode = 7'h05;
		cyc(4);
		rdc(FLT, 16'h0700, 16'hffff);
		biasCode = 7'h06;
		cyc(1);
		biasCode = 7'h05;
		cyc(4);
		drv(1'b1);
		rdc(LIM, 16'h0005, 16'hffff);
		rdc(FLT, 16'h0121, 16'hffff);
		softEn = 1'b0;
		cyc(8);
		rdc(FLT, 16'h0140, 16'hffff);
		softEn = 1'b1;
		cyc(100);
		rdc(FLT, 16'h0700, 16'hffff);
	endtask
	task automatic t_detectors;
		logic [15:0] b;
		logic        hit;
		lockEn = 1'b0;
		cfgWord = 16'h0047;
		for (int m = 0; m < 2; m++) begin
			loopMode = m[0];
			for (int k = 1; k < 4; k++) begin
				evt(k);
				cyc(4);
				b = 16'h1 << k;
				hit = (m == 1 || k == 3);
				drv(!hit);
				rdc(FLT, hit ? b : 16'h0, b);
				reen;
			end
		end
	endtask
	task automatic t_lockout;
		lockEn = 1'b1;
		evt(4);
		softEn = 1'b0;
		cyc(8);
		softEn = 1'b1;
		cyc(10);
		evt(4);
		rdc(FLT, 16'h0090, 16'h0090);
		reen;
		cyc(20);
		drv(1'b0);
	endtask
	// hang guard, well above the roughly 8200 cycles the sequence takes
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			test_done;
		end
	end
	initial begin
		cyc(4);
		arst_n = 1'b1;
		cyc(12);
		t_powerUp;
		t_enable;
		t_overCurrent;
		t_detectors;
		t_lockout;
		test_done;
	end
endmodule
`default_nettype wire
